// [core/lmh_sequencer.sv]
// operation select and home-seeking sequencer, legacy position mode
// assumes pins arrive asynchronous; motion core acts on the run outputs
//
// Notes on behaviour
// - speed/torque source: 0 digital, 1 analog speed, 2 analog torque; reset 1.
// - continuous enable makes numbers 0 and 1 continuous runs.
// - continuous enable resets to 0, so 0 and 1 position.
// - on start, number 6 runs electrical home, number 7 mechanical home.
// - power-up position is stored as electrical home and targeted later.
// - mechanical homing starts in seek direction setting; reset 1 positive.
// - reverse on sensor off position, stop on sensor on position.
// - forward search uses speed of operation number 7.
// - reverse phase at 60 r/min, or number 7 speed if lower.
// - number 7 speed zero gives abnormal-data alarm, no motion.
// - position unknown shown after reset, homing, continuous, jog, stops, preset.
// - operation number is binary of select bits, bit 0 lsb; bit 3 optional.
`timescale 1ns/1ps
`default_nettype none
`include "lmh_regs.svh"
module lmh_sequencer
	import lmh_pkg::*;
(
	input wire logic core_clk, // 25 MHz core clock
	input wire logic nrst, // synchronous reset, low
	input wire logic op_select_bit0, // select pin bit 0
	input wire logic op_select_bit1, // select pin bit 1
	input wire logic op_select_bit2, // select pin bit 2
	input wire logic op_select_bit3, // select pin bit 3
	input wire logic select_bit3_assigned, // bit 3 pin in use
	input wire logic start_input, // start pin
	input wire logic decel_stop_input, // decel_stop_input/stop pin, high allows motion
	input wire logic home_sensor_input, // home sensor pin, high is on
	input wire logic manual_inch_motion, // jog in progress
	input wire logic alarm_reset, // alarm reset pulse
	input wire logic excitation_off, // free or servo-off active
	input wire logic position_preset, // preset pulse
	input wire logic [1:0] speed_src_cfg, // speed/torque source value
	input wire logic speed_src_wr, // load speed_src_cfg
	input wire logic cont_run_cfg, // continuous enable value
	input wire logic cont_run_wr, // load cont_run_cfg
	input wire logic seek_dir_cfg, // seek direction value
	input wire logic seek_dir_wr, // load seek_dir_cfg
	input wire logic speed_wr, // write operating speed table
	input wire logic [3:0] speed_wr_addr, // operation number written
	input wire lmh_speed_t speed_wr_data, // speed in r/min
	input wire logic signed [31:0] motor_position, // current position
	input wire logic move_done, // motion core reached target
	output logic [1:0] speed_src, // active source setting
	output logic cont_run_en, // active continuous enable
	output logic seek_dir, // active seek direction
	output logic run_position, // positioning move active
	output logic run_continuous, // continuous run active
	output logic run_home, // homing motion active
	output logic move_dir, // 1 positive, 0 negative
	output lmh_speed_t move_speed, // commanded speed
	output logic signed [31:0] target_position, // positioning target
	output logic [3:0] active_op, // latched operation number
	output logic [4:0] op_display, // number or unknown code
	output logic position_unknown_indication, // unknown state flag
	output logic op_data_alarm // abnormal operation data alarm
);
	////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [7:0] pins_raw;
	logic [7:0] pins_s;
	assign pins_raw = {op_select_bit3, op_select_bit2, op_select_bit1, op_select_bit0,
		start_input, decel_stop_input, home_sensor_input, 1'h0};
	genvar gi;
	generate
		for (gi = 1; gi < 8; gi++) begin : g_sync
			lmh_sync u_sync (
				.core_clk(core_clk),
				.nrst(nrst),
				.pin_in(pins_raw[gi]),
				.sync_out(pins_s[gi])
			);
		end
	endgenerate
	assign pins_s[0] = 1'h0;
	logic start_s;
	logic decel_stop_input_s;
	logic sensor_s;
	assign start_s = pins_s[3];
	assign decel_stop_input_s = pins_s[2];
	assign sensor_s = pins_s[1];

	// binary of the select bits, bit 3 only when assigned
	function automatic logic [3:0] op_number(input logic [3:0] bits, input logic use3);
		op_number = {bits[3] & use3, bits[2:0]};
	endfunction : op_number

	// reverse speed is the lower of 60 r/min and the table speed
	function automatic lmh_speed_t rev_speed(input lmh_speed_t s);
		rev_speed = (s <= `LMH_REV_SPEED_RPM) ? s : `LMH_REV_SPEED_RPM;
	endfunction : rev_speed

	////////////////////////////////////////////////////////////////
	// speed table
	logic [3:0] rd_addr;
	lmh_speed_t rd_speed;
	lmh_speed_mem u_mem (
		.core_clk(core_clk),
		.wr_en(speed_wr),
		.wr_addr(speed_wr_addr),
		.wr_data(speed_wr_data),
		.rd_addr(rd_addr),
		.rd_data(rd_speed)
	);

	////////////////////////////////////////////////////////////////
	// settings
	logic [1:0] next_speed_src;
	logic next_cont_run_en;
	logic next_seek_dir;
	// a reserved value 3 is refused, keeping the old source
	always_comb begin
		next_speed_src = speed_src;
		next_cont_run_en = cont_run_en;
		next_seek_dir = seek_dir;
		if (speed_src_wr && speed_src_cfg != 2'h3) begin
			next_speed_src = speed_src_cfg;
		end
		if (cont_run_wr) begin
			next_cont_run_en = cont_run_cfg;
		end
		if (seek_dir_wr) begin
			next_seek_dir = seek_dir_cfg;
		end
	end
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			speed_src <= `LMH_SRC_RESET;
			cont_run_en <= `LMH_CONT_RESET;
			seek_dir <= `LMH_DIR_RESET;
		end else begin
			speed_src <= next_speed_src;
			cont_run_en <= next_cont_run_en;
			seek_dir <= next_seek_dir;
		end
	end

	////////////////////////////////////////////////////////////////
	// sequencer
	lmh_state_t state, next_state;
	logic start_d, next_start_d;
	logic pending, next_pending;
	logic home_valid, next_home_valid;
	logic signed [31:0] elec_home, next_elec_home;
	logic [3:0] next_active_op;
	logic next_run_position, next_run_continuous, next_run_home, next_move_dir;
	lmh_speed_t next_move_speed;
	logic signed [31:0] next_target;
	logic next_unknown, next_alarm;
	logic start_rise;
	assign start_rise = start_s & ~start_d;
	assign rd_addr = next_active_op; // new number addressed at take, so the word is ready with pending

	// pending waits one cycle for the registered table read
	always_comb begin
		next_state = state;
		next_start_d = start_s;
		next_pending = 1'h0;
		next_home_valid = 1'h1;
		next_elec_home = elec_home;
		next_active_op = active_op;
		next_run_position = run_position;
		next_run_continuous = run_continuous;
		next_run_home = run_home;
		next_move_dir = move_dir;
		next_move_speed = move_speed;
		next_target = target_position;
		next_unknown = position_unknown_indication;
		next_alarm = op_data_alarm;
		if (!home_valid) begin
			next_elec_home = motor_position;
		end
		if (alarm_reset) begin
			next_alarm = 1'h0;
			next_unknown = 1'h1;
		end
		if (manual_inch_motion || position_preset || excitation_off) begin
			next_unknown = 1'h1;
		end
		case (state)
			lmh_idle: begin
				next_run_position = 1'h0;
				next_run_continuous = 1'h0;
				next_run_home = 1'h0;
				// motion refused while decel_stop_input/stop input is off or alarmed
				if (start_rise && decel_stop_input_s && !op_data_alarm) begin
					next_active_op = op_number(pins_s[7:4], select_bit3_assigned);
					next_pending = 1'h1;
				end
				if (pending) begin
					next_move_speed = rd_speed;
					if (active_op == `LMH_OP_ELEC_HOME) begin
						next_state = lmh_elec_home;
						next_run_home = 1'h1;
						next_target = elec_home;
						next_unknown = 1'h1;
					end else if (active_op == `LMH_OP_MECH_HOME) begin
						if (rd_speed == 16'h0000) begin
							next_alarm = 1'h1;
							next_unknown = 1'h1;
						end else begin
							next_state = lmh_mech_seek;
							next_run_home = 1'h1;
							next_move_dir = seek_dir;
							next_unknown = 1'h1;
						end
					end else if (cont_run_en && active_op[3:1] == 3'h0) begin
						next_state = lmh_continuous;
						next_run_continuous = 1'h1;
						next_unknown = 1'h1;
					end else begin
						next_state = lmh_position;
						next_run_position = 1'h1;
						next_unknown = 1'h0;
					end
				end
			end
			lmh_position: begin
				if (move_done) begin
					next_state = lmh_idle;
					next_run_position = 1'h0;
				end
			end
			lmh_continuous: begin
				// continuous run lasts while start is held
				if (!start_s) begin
					next_state = lmh_idle;
					next_run_continuous = 1'h0;
				end
			end
			lmh_elec_home: begin
				if (move_done) begin
					next_state = lmh_idle;
					next_run_home = 1'h0;
				end
			end
			lmh_mech_seek: begin
				if (!sensor_s) begin
					next_state = lmh_mech_reverse;
					next_move_dir = ~move_dir;
					next_move_speed = rev_speed(move_speed);
				end
			end
			lmh_mech_reverse: begin
				if (sensor_s) begin
					next_state = lmh_idle;
					next_run_home = 1'h0;
				end
			end
			default: begin
				next_state = lmh_idle;
			end
		endcase
		// decel_stop_input stop ends any motion and loses the position
		if (!decel_stop_input_s && state != lmh_idle) begin
			next_state = lmh_idle;
			next_run_position = 1'h0;
			next_run_continuous = 1'h0;
			next_run_home = 1'h0;
			next_unknown = 1'h1;
		end
		if (excitation_off) begin
			next_state = lmh_idle;
			next_run_position = 1'h0;
			next_run_continuous = 1'h0;
			next_run_home = 1'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state <= lmh_idle;
			start_d <= 1'h0;
			pending <= 1'h0;
			home_valid <= 1'h0;
			elec_home <= 32'sh0;
			active_op <= 4'h0;
			run_position <= 1'h0;
			run_continuous <= 1'h0;
			run_home <= 1'h0;
			move_dir <= `LMH_DIR_RESET;
			move_speed <= 16'h0000;
			target_position <= 32'sh0;
			position_unknown_indication <= 1'h1;
			op_data_alarm <= 1'h0;
		end else begin
			state <= next_state;
			start_d <= next_start_d;
			pending <= next_pending;
			home_valid <= next_home_valid;
			elec_home <= next_elec_home;
			active_op <= next_active_op;
			run_position <= next_run_position;
			run_continuous <= next_run_continuous;
			run_home <= next_run_home;
			move_dir <= next_move_dir;
			move_speed <= next_move_speed;
			target_position <= next_target;
			position_unknown_indication <= next_unknown;
			op_data_alarm <= next_alarm;
		end
	end

	// display register updates in the same cycle as the unknown flag
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			op_display <= `LMH_POS_UNKNOWN_CODE;
		end else begin
			op_display <= next_unknown ? `LMH_POS_UNKNOWN_CODE : {1'h0, next_active_op};
		end
	end
endmodule : lmh_sequencer
`default_nettype wire

// [core/lmh_regs.svh]
// reverse speed, reset values and codes for the homing sequencer
// assumes inclusion by bare name from the package and the modules
`ifndef LMH_REGS_SVH
`define LMH_REGS_SVH
`define LMH_SRC_RESET 2'h1
`define LMH_SRC_DIGITAL 2'h0
`define LMH_SRC_ANALOG_SPEED 2'h1
`define LMH_SRC_ANALOG_TORQUE 2'h2
`define LMH_CONT_RESET 1'h0
`define LMH_DIR_RESET 1'h1
`define LMH_OP_ELEC_HOME 4'h6
`define LMH_OP_MECH_HOME 4'h7
`define LMH_REV_SPEED_RPM 16'h003c
`define LMH_POS_UNKNOWN_CODE 5'h1f
`endif

// [core/lmh_pkg.sv]
// types shared by the homing sequencer files
// assumes lmh_regs.svh sits on the include path
`include "lmh_regs.svh"
package lmh_pkg;
	typedef enum logic [2:0] {
		lmh_idle,
		lmh_position,
		lmh_continuous,
		lmh_elec_home,
		lmh_mech_seek,
		lmh_mech_reverse
	} lmh_state_t;
	typedef logic [15:0] lmh_speed_t;
endpackage : lmh_pkg

// [core/lmh_sync.sv]
// two flip-flop synchroniser for one pin-side input
// assumes the input is asynchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module lmh_sync (
	input wire logic core_clk, // core clock
	input wire logic nrst, // synchronous reset, low
	input wire logic pin_in, // raw pin level
	output logic sync_out // synchronised level
);
	logic stage1;
	// first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			stage1 <= 1'h0;
			sync_out <= 1'h0;
		end else begin
			stage1 <= pin_in;
			sync_out <= stage1;
		end
	end
endmodule : lmh_sync
`default_nettype wire

// [core/lmh_speed_mem.sv]
// sixteen-word table of operating speeds, one per operation number
// assumes the host side writes words one at a time on core_clk
`timescale 1ns/1ps
`default_nettype none
module lmh_speed_mem
	import lmh_pkg::*;
(
	input wire logic core_clk, // core clock
	input wire logic wr_en, // write strobe
	input wire logic [3:0] wr_addr, // word written
	input wire lmh_speed_t wr_data, // speed in r/min
	input wire logic [3:0] rd_addr, // word read
	output lmh_speed_t rd_data // registered read data
);
	lmh_speed_t mem [0:15];
	// one-cycle registered read
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : lmh_speed_mem
`default_nettype wire

// [tb/lmh_seq_chk.sv]
// assertions on the sequencer top ports
// assumes lmh_pkg and lmh_regs.svh compiled first
`timescale 1ns/1ps
`default_nettype none
`include "lmh_regs.svh"
module lmh_seq_chk
	import lmh_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic nrst, // reset, low
	input wire logic decel_stop_input, // stop pin
	input wire logic [1:0] speed_src, // source
	input wire logic cont_run_en, // cont enable
	input wire logic seek_dir, // seek dir
	input wire logic run_position, // pos run
	input wire logic run_continuous, // cont run
	input wire logic run_home, // home run
	input wire logic move_dir, // direction
	input wire lmh_speed_t move_speed, // speed
	input wire logic [3:0] active_op, // op number
	input wire logic [4:0] op_display, // display
	input wire logic position_unknown_indication, // unknown
	input wire logic op_data_alarm // alarm
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic moving;
	// any motion at all
	assign moving = run_position | run_continuous | run_home;
	////////////////////////////////
	a_reset_values: assert property (disable iff (1'b0) !nrst |=> speed_src == `LMH_SRC_RESET
		&& cont_run_en == `LMH_CONT_RESET && seek_dir == `LMH_DIR_RESET && position_unknown_indication)
		else $error("setting not at reset value");
	a_home_dir: assert property ($rose(run_home) && active_op == `LMH_OP_MECH_HOME
		|-> move_dir == seek_dir) else $error("homing started off seek direction");
	a_home_op: assert property ($rose(run_home) |-> active_op inside {`LMH_OP_ELEC_HOME, `LMH_OP_MECH_HOME})
		else $error("homing from wrong number");
	a_rev_speed: assert property (run_home && $past(run_home) && move_dir != $past(move_dir)
		|-> move_speed <= `LMH_REV_SPEED_RPM) else $error("reverse speed too high");
	a_alarm_still: assert property (op_data_alarm |-> !moving)
		else $error("motion with data alarm");
	a_unknown_run: assert property (run_home || run_continuous |-> position_unknown_indication
		&& op_display == `LMH_POS_UNKNOWN_CODE) else $error("unknown not shown");
	a_cont_range: assert property (run_continuous |-> cont_run_en && active_op[3:1] == 3'h0)
		else $error("continuous run on wrong number");
	a_op_held: assert property (moving && $past(moving) |-> $stable(active_op))
		else $error("latched number moved");
	a_decel_stop_input_halts: assert property (!decel_stop_input [*5] |-> !moving)
		else $error("motion with stop low");
	c_cont: cover property (run_continuous);
	c_rev: cover property (run_home && move_dir != seek_dir);
	c_alarm: cover property (op_data_alarm);
endmodule : lmh_seq_chk
bind lmh_sequencer lmh_seq_chk u_chk (.core_clk(core_clk), .nrst(nrst), .decel_stop_input(decel_stop_input),
	.speed_src(speed_src), .cont_run_en(cont_run_en), .seek_dir(seek_dir), .run_position(run_position),
	.run_continuous(run_continuous), .run_home(run_home), .move_dir(move_dir), .move_speed(move_speed),
	.active_op(active_op), .op_display(op_display), .op_data_alarm(op_data_alarm),
	.position_unknown_indication(position_unknown_indication));
`default_nettype wire

// [tb/lmh_motion_model.sv]
// motion core stand-in: reports arrival a set time after a move starts
// assumes go stays high until the sequencer drops the move
`timescale 1ns/1ps
`default_nettype none
module lmh_motion_model (
	input wire logic core_clk, // clock
	input wire logic go, // target move active
	input wire logic [3:0] dly, // cycles to arrive
	output logic move_done // arrival pulse
);
	logic [4:0] cnt = 5'h00;
	// count time since move start; slow dly lets a stop cut in
	always_ff @(posedge core_clk) begin
		cnt <= go ? cnt + 5'h01 : 5'h00;
	end
	assign move_done = go && cnt == {1'h0, dly};
endmodule : lmh_motion_model
`default_nettype wire

// [tb/tb_legacy_mode_homing_sequencer.sv]
// self-checking bench for the homing sequencer
// assumes design files, checker and motion model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_legacy_mode_homing_sequencer
	import lmh_pkg::*;
;
	typedef struct packed {logic [3:0] s; logic a; logic c; logic [1:0] k; logic [3:0] op;} lmh_row_t;
	logic core_clk = 1'h0, nrst = 1'h0, start_input = 1'h0, decel_stop_input = 1'h1, home_sensor_input = 1'h1;
	logic op_select_bit0 = 1'h0, op_select_bit1 = 1'h0, op_select_bit2 = 1'h0, op_select_bit3 = 1'h0;
	logic select_bit3_assigned = 1'h0, alarm_reset = 1'h0, speed_src_wr = 1'h0, cont_run_cfg = 1'h0;
	logic manual_inch_motion = 1'h0, excitation_off = 1'h0, position_preset = 1'h0;
	logic cont_run_wr = 1'h0, seek_dir_cfg = 1'h0, seek_dir_wr = 1'h0, speed_wr = 1'h0, move_done;
	logic [1:0] speed_src_cfg = 2'h0, speed_src;
	logic [3:0] speed_wr_addr = 4'h0, dly = 4'h6, active_op;
	lmh_speed_t speed_wr_data = 16'h0000, move_speed;
	logic signed [31:0] motor_position = 32'h00001234, target_position;
	logic cont_run_en, seek_dir, run_position, run_continuous, run_home, move_dir, position_unknown_indication;
	logic op_data_alarm;
	logic [4:0] op_display;
	int errors = 0, checks = 0;
	lmh_row_t rows [8] = '{'{4'h0, 1'h0, 1'h0, 2'h0, 4'h0}, '{4'h1, 1'h0, 1'h1, 2'h1, 4'h1},
		'{4'h0, 1'h0, 1'h1, 2'h1, 4'h0}, '{4'h5, 1'h0, 1'h0, 2'h0, 4'h5}, '{4'h6, 1'h0, 1'h0, 2'h2, 4'h6},
		'{4'h9, 1'h1, 1'h0, 2'h0, 4'h9}, '{4'hf, 1'h1, 1'h0, 2'h0, 4'hf}, '{4'h8, 1'h0, 1'h0, 2'h0, 4'h0}};
	// 25 MHz core clock
	always #20 core_clk = ~core_clk;
	lmh_sequencer DUT (.core_clk(core_clk), .nrst(nrst), .op_select_bit0(op_select_bit0),
		.op_select_bit1(op_select_bit1), .op_select_bit2(op_select_bit2), .op_select_bit3(op_select_bit3),
		.select_bit3_assigned(select_bit3_assigned), .start_input(start_input), .decel_stop_input(decel_stop_input),
		.home_sensor_input(home_sensor_input), .manual_inch_motion(manual_inch_motion), .alarm_reset(alarm_reset),
		.excitation_off(excitation_off), .position_preset(position_preset), .speed_src_cfg(speed_src_cfg),
		.speed_src_wr(speed_src_wr),
		.cont_run_cfg(cont_run_cfg), .cont_run_wr(cont_run_wr), .seek_dir_cfg(seek_dir_cfg),
		.seek_dir_wr(seek_dir_wr), .speed_wr(speed_wr), .speed_wr_addr(speed_wr_addr), .speed_wr_data(speed_wr_data),
		.motor_position(motor_position), .move_done(move_done), .speed_src(speed_src), .cont_run_en(cont_run_en),
		.seek_dir(seek_dir), .run_position(run_position), .run_continuous(run_continuous), .run_home(run_home),
		.move_dir(move_dir), .move_speed(move_speed), .target_position(target_position), .active_op(active_op),
		.op_display(op_display), .position_unknown_indication(position_unknown_indication),
		.op_data_alarm(op_data_alarm));
	lmh_motion_model u_mot (.core_clk(core_clk), .go(run_position | (run_home & (active_op == 4'h6))),
		.dly(dly), .move_done(move_done));
	////////////////////////////////
	task automatic close_out();
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// bounded wait: 0 motion or alarm, 1 all idle, 2 reversed
	task automatic wait_on(input int c);
		int n;
		for (n = 0; n < 40; n++) begin
			if (c == 0 && (run_position | run_continuous | run_home | op_data_alarm) === 1'h1) break;
			if (c == 1 && (run_position | run_continuous | run_home) === 1'h0) break;
			if (c == 2 && move_dir !== seek_dir) break;
			@(negedge core_clk);
		end
		if (n == 40) begin
			errors++;
			close_out();
		end
	endtask : wait_on
	// select first, start later, as the controller must
	task automatic go(input logic [3:0] s, input logic a);
		{op_select_bit3, op_select_bit2, op_select_bit1, op_select_bit0} = s;
		select_bit3_assigned = a;
		repeat (4) @(negedge core_clk);
		start_input = 1'h1;
	endtask : go
	task automatic wr_speed(input logic [3:0] a, input lmh_speed_t d);
		speed_wr_addr = a;
		speed_wr_data = d;
		speed_wr = 1'h1;
		@(negedge core_clk);
		speed_wr = 1'h0;
	endtask : wr_speed
	task automatic mech(input lmh_speed_t sp, input lmh_speed_t rev, input logic d);
		seek_dir_cfg = d;
		seek_dir_wr = 1'h1;
		@(negedge core_clk);
		seek_dir_wr = 1'h0;
		chk(seek_dir, d);
		wr_speed(4'h7, sp);
		home_sensor_input = 1'h1;
		go(4'h7, 1'h0);
		wait_on(0);
		chk(move_dir, d);
		chk(move_speed, sp);
		start_input = 1'h0;
		home_sensor_input = 1'h0;
		wait_on(2);
		chk(move_speed, rev);
		chk(run_home, 1'h1);
		home_sensor_input = 1'h1;
		wait_on(1);
	endtask : mech
	////////////////////////////////
	// main sequence, stop input held on except for the mid-move stop check
	initial begin
		repeat (12) @(negedge core_clk);
		nrst = 1'h1;
		@(negedge core_clk);
		chk({speed_src, cont_run_en, seek_dir}, 4'h5);
		chk({position_unknown_indication, op_display}, 6'h3f);
		motor_position = 32'h00005678;
		for (int i = 0; i < 4; i++) begin
			speed_src_cfg = i[1:0];
			speed_src_wr = 1'h1;
			@(negedge core_clk);
			speed_src_wr = 1'h0;
			@(negedge core_clk);
			chk(speed_src, (i == 3) ? 2 : i);
		end
		foreach (rows[i]) begin
			cont_run_cfg = rows[i].c;
			cont_run_wr = 1'h1;
			@(negedge core_clk);
			cont_run_wr = 1'h0;
			go(rows[i].s, rows[i].a);
			wait_on(0);
			{op_select_bit3, op_select_bit2, op_select_bit1, op_select_bit0} = ~rows[i].s;
			repeat (3) @(negedge core_clk);
			chk(active_op, rows[i].op);
			chk({run_home, run_continuous, run_position}, 3'h1 << rows[i].k);
			chk(position_unknown_indication, rows[i].k != 2'h0);
			chk(op_display, (rows[i].k != 2'h0) ? 5'h1f : {1'h0, rows[i].op});
			if (rows[i].k == 2'h2) chk(target_position, 32'h00001234);
			start_input = 1'h0;
			wait_on(1);
		end
		mech(16'h0064, 16'h003c, 1'h0);
		mech(16'h0028, 16'h0028, 1'h1);
		wr_speed(4'h7, 16'h0000);
		go(4'h7, 1'h0);
		wait_on(0);
		chk({op_data_alarm, run_home}, 2'h2);
		start_input = 1'h0;
		repeat (4) @(negedge core_clk);
		go(4'h2, 1'h0);
		repeat (10) @(negedge core_clk);
		chk(run_position, 1'h0);
		start_input = 1'h0;
		alarm_reset = 1'h1;
		@(negedge core_clk);
		alarm_reset = 1'h0;
		repeat (2) @(negedge core_clk);
		chk({op_data_alarm, position_unknown_indication}, 2'h1);
		dly = 4'hf;
		go(4'h2, 1'h0);
		wait_on(0);
		decel_stop_input = 1'h0;
		wait_on(1);
		chk(position_unknown_indication, 1'h1);
		decel_stop_input = 1'h1;
		start_input = 1'h0;
		// jog, excitation release and preset each lose a known position
		for (int j = 0; j < 3; j++) begin
			go(4'h3, 1'h0);
			wait_on(0);
			chk(position_unknown_indication, 1'h0);
			{position_preset, excitation_off, manual_inch_motion} = 3'h1 << j;
			@(negedge core_clk);
			{position_preset, excitation_off, manual_inch_motion} = 3'h0;
			start_input = 1'h0;
			wait_on(1);
			chk(position_unknown_indication, 1'h1);
		end
		// second reset in mid-move: settings return, new power-up position taken
		go(4'h3, 1'h0);
		wait_on(0);
		nrst = 1'h0;
		start_input = 1'h0;
		repeat (4) @(negedge core_clk);
		chk({run_home, run_continuous, run_position, position_unknown_indication}, 4'h1);
		motor_position = 32'h00009abc;
		nrst = 1'h1;
		@(negedge core_clk);
		motor_position = 32'h00001111;
		chk({speed_src, cont_run_en, seek_dir}, 4'h5);
		chk({position_unknown_indication, op_display}, 6'h3f);
		go(4'h6, 1'h0);
		wait_on(0);
		chk(target_position, 32'h00009abc);
		start_input = 1'h0;
		wait_on(1);
		close_out();
	end
endmodule : tb_legacy_mode_homing_sequencer
`default_nettype wire
